// ===== verilog/srp_pkg.sv
// srp_pkg: constants shared by the serial register port.
// assumes a single 40 MHz core clock; the link signals are
// oversampled by that clock.
package srp_pkg;
  // core clock and sampled link timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  // address and data layout
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int SHORT_ADDR_W = 7;
  localparam int LONG_HI_W = 4;
  localparam logic [2:0] LONG_PREFIX = 3'h7;
  localparam int DIR_BIT = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // status word, cell 0 is sent first
  localparam int STAT_W = 16;
  localparam int CNT_W = 16;
  // write buffer
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = ADDR_W + DATA_W;
  localparam logic [1:0] BUF_FULL_CNT = 2'h2;
  // values after reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [STAT_W-1:0] TX_RST = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  typedef enum logic [1:0] {
    SRP_ADDR0,
    SRP_ADDR1,
    SRP_DATA
  } srp_phase_e;
endpackage : srp_pkg

// ===== verilog/srp_port.sv
// srp_port: four-wire serial slave that gives a host access to the
// register file and shifts out a status word during the address phase.
// assumes: register file and status sources run on mclk; the serial
// clock half period spans at least three mclk cycles.
//
// Overview of operation
// - the port stays usable in every power mode; only a low ce freezes it.
// - a low chip select opens an access and MOSI becomes a register access.
// - an access is one or two address bytes, the first with a direction bit, then data bytes.
// - direction bit zero reads and one writes.
// - reads drive register data on MISO, writes take data from MOSI.
// - addresses below 0x70 may use the single-byte short address form.
// - the address counter steps by one after each data byte.
// - a burst runs on for as many bytes as the host clocks.
// - bursts auto-increment in the long address form as well.
// - the status word goes out on MISO while the address is shifted in.
// - cell 0 reads one, or zero while power is not yet ready.
// - cells 1 to 7 give lock, over, under, free, count, full, empty.
// - free and count threshold bits use a strict greater-than.
// - long form cells 8 to 14 give power and event flags, cell 15 internal.
// - leaving deepest sleep, MISO stays low until ready then rises.
`timescale 1ns/10ps
module srp_port
  import srp_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic spi_cs_n,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic power_ready,
  input wire logic pll_lock,
  input wire logic fifo_over,
  input wire logic fifo_under,
  input wire logic [CNT_W-1:0] fifo_free_space,
  input wire logic [CNT_W-1:0] fifo_fill_count,
  input wire logic [CNT_W-1:0] fifo_threshold_level,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic power_good_flag,
  input wire logic pwr_irq_pending,
  input wire logic radio_event_pending,
  input wire logic xtal_running,
  input wire logic wakeup_irq_pending,
  input wire logic low_power_oscillator_irq,
  input wire logic auxiliary_adc_irq,
  output logic rd_req,
  output logic [ADDR_W-1:0] reg_raddr,
  input wire logic [DATA_W-1:0] reg_rdata,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic wr_overrun,
  input wire logic wr_overrun_clr,
  output logic access_busy
);

  // link synchronisers: stage 1 feeds stage 2 only
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic mosi_s1_r, mosi_s2_r;
  logic cs_s1_r, cs_s2_r, cs_s3_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else if (ce) begin
      sck_s1_r <= spi_sclk;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      mosi_s1_r <= spi_mosi;
      mosi_s2_r <= mosi_s1_r;
      cs_s1_r <= spi_cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  logic cs_act, cs_fall, sck_rise, sck_fall;
  assign cs_act = ~cs_s2_r;
  assign cs_fall = ~cs_s2_r & cs_s3_r;
  assign sck_rise = cs_act & sck_s2_r & ~sck_s3_r;
  assign sck_fall = cs_act & ~sck_s2_r & sck_s3_r;

  // bit assembly
  logic [2:0] bit_cnt_r;
  logic [DATA_W-1:0] sh_in_r;
  logic [DATA_W-1:0] in_byte;
  logic byte_done;
  logic started_r;
  assign in_byte = {sh_in_r[DATA_W-2:0], mosi_s2_r};
  assign byte_done = sck_rise & (bit_cnt_r == LAST_BIT);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bit_cnt_r <= 3'h0;
      sh_in_r <= BYTE_RST;
      started_r <= 1'b0;
    end else if (ce) begin
      if (!cs_act) begin
        bit_cnt_r <= 3'h0;
        sh_in_r <= BYTE_RST;
        started_r <= 1'b0;
      end else if (sck_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        sh_in_r <= in_byte;
        started_r <= 1'b1;
      end
    end
  end

  // access phase and address counter
  srp_phase_e phase_r;
  logic [ADDR_W-1:0] addr_r;
  logic wr_mode_r;
  logic long_hdr;
  assign long_hdr = (in_byte[6:4] == LONG_PREFIX);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase_r <= SRP_ADDR0;
    end else if (ce) begin
      if (!cs_act) begin
        phase_r <= SRP_ADDR0;
      end else if (byte_done) begin
        unique case (phase_r)
          SRP_ADDR0: phase_r <= long_hdr ? SRP_ADDR1 : SRP_DATA;
          SRP_ADDR1: phase_r <= SRP_DATA;
          SRP_DATA: phase_r <= SRP_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_r <= ADDR_RST;
      wr_mode_r <= 1'b0;
    end else if (ce && byte_done) begin
      unique case (phase_r)
        SRP_ADDR0: begin
          wr_mode_r <= in_byte[DIR_BIT];
          if (long_hdr) begin
            addr_r <= {in_byte[LONG_HI_W-1:0], BYTE_RST};
          end else begin
            addr_r <= {5'h00, in_byte[SHORT_ADDR_W-1:0]};
          end
        end
        SRP_ADDR1: addr_r <= {addr_r[ADDR_W-1:DATA_W], in_byte};
        SRP_DATA: addr_r <= addr_r + 12'h001;
      endcase
    end
  end

  // read fetch: the register file answers in the cycle of rd_req
  logic rd_req_r, load_pend_r;
  logic [DATA_W-1:0] rd_byte_r;
  logic fetch;
  always_comb begin
    fetch = 1'b0;
    if (byte_done) begin
      unique case (phase_r)
        SRP_ADDR0: fetch = ~in_byte[DIR_BIT] & ~long_hdr;
        SRP_ADDR1: fetch = ~wr_mode_r;
        SRP_DATA: fetch = ~wr_mode_r;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_req_r <= 1'b0;
      rd_byte_r <= BYTE_RST;
      load_pend_r <= 1'b0;
    end else if (ce) begin
      rd_req_r <= fetch & cs_act;
      if (!cs_act) begin
        load_pend_r <= 1'b0;
      end else if (rd_req_r) begin
        rd_byte_r <= reg_rdata;
        load_pend_r <= 1'b1;
      end else if (sck_fall) begin
        load_pend_r <= 1'b0;
      end
    end
  end
  assign rd_req = rd_req_r;
  assign reg_raddr = addr_r;

  // status snapshot, cell 0 in the top bit so it leaves first
  logic [STAT_W-1:0] stat_word;
  logic thr_free, thr_count;
  assign thr_free = fifo_free_space > fifo_threshold_level;
  assign thr_count = fifo_fill_count > fifo_threshold_level;
  assign stat_word = {power_ready, pll_lock, fifo_over, fifo_under,
                      thr_free, thr_count, fifo_full, fifo_empty,
                      power_good_flag, pwr_irq_pending, radio_event_pending,
                      xtal_running, wakeup_irq_pending, low_power_oscillator_irq,
                      auxiliary_adc_irq, 1'b0};

  // MISO shifter; the status is taken at select, then cell 0 follows power_ready until the first clock
  logic [STAT_W-1:0] tx_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_r <= TX_RST;
    end else if (ce) begin
      if (cs_fall) begin
        tx_r <= stat_word;
      end else if (sck_fall) begin
        if (load_pend_r) begin
          tx_r <= {rd_byte_r, BYTE_RST};
        end else begin
          tx_r <= {tx_r[STAT_W-2:0], 1'b0};
        end
      end else if (cs_act && !started_r) begin
        // host polls here after deepest sleep, no clock running yet
        tx_r[STAT_W-1] <= power_ready;
      end
    end
  end
  assign spi_miso = tx_r[STAT_W-1];
  assign spi_miso_oe_n = cs_s2_r;
  assign access_busy = cs_act;

  // two-entry write buffer; a full buffer drops the word and flags it
  logic push, buf_in_ready, pop;
  logic [BUF_W-1:0] buf_mem_r [BUF_DEPTH];
  logic wp_r, rp_r;
  logic [1:0] buf_cnt_r;
  logic overrun_r;
  assign push = byte_done & cs_act & (phase_r == SRP_DATA) & wr_mode_r;
  assign buf_in_ready = (buf_cnt_r != BUF_FULL_CNT);
  assign pop = wr_valid & wr_ready;
  // no offer while frozen, or the sink would take a word that is never popped
  assign wr_valid = ce & (buf_cnt_r != 2'h0);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      buf_cnt_r <= 2'h0;
    end else if (ce) begin
      if (push && buf_in_ready) begin
        buf_mem_r[wp_r] <= {addr_r, in_byte};
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, push & buf_in_ready} - {1'b0, pop};
    end
  end
  assign wr_addr = buf_mem_r[rp_r][BUF_W-1:DATA_W];
  assign wr_data = buf_mem_r[rp_r][DATA_W-1:0];

  // set wins over clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      overrun_r <= 1'b0;
    end else if (ce) begin
      if (push && !buf_in_ready) begin
        overrun_r <= 1'b1;
      end else if (wr_overrun_clr) begin
        overrun_r <= 1'b0;
      end
    end
  end
  assign wr_overrun = overrun_r;

  // checks
  a_idle_no_drive: assert property (@(posedge mclk) disable iff (sys_rst)
    !cs_act |-> spi_miso_oe_n) else $error("miso driven while deselected");
  a_dir_decode: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && byte_done && phase_r == SRP_ADDR0 |=> wr_mode_r == $past(in_byte[DIR_BIT]))
    else $error("direction bit misdecoded");
  a_short_addr: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cs_act && byte_done && phase_r == SRP_ADDR0 && !long_hdr
    |=> phase_r == SRP_DATA && addr_r[ADDR_W-1:SHORT_ADDR_W] == 5'h00)
    else $error("short address not taken");
  a_long_addr: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cs_act && byte_done && phase_r == SRP_ADDR0 && long_hdr
    |=> phase_r == SRP_ADDR1) else $error("long address form missed");
  a_addr_step: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && byte_done && phase_r == SRP_DATA |=> addr_r == $past(addr_r) + 12'h001)
    else $error("address did not step");
  a_burst_stays: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cs_act && phase_r == SRP_DATA ##1 cs_act |-> phase_r == SRP_DATA)
    else $error("burst left data phase");
  a_read_fetch: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cs_act && byte_done && phase_r == SRP_DATA && !wr_mode_r
    |=> rd_req ##1 load_pend_r) else $error("read data not fetched");
  a_write_push: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && push && buf_in_ready |=> wr_valid) else $error("write word lost");
  a_cs_abort: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && !cs_act |=> bit_cnt_r == 3'h0 && phase_r == SRP_ADDR0)
    else $error("access not ended by deselect");
  a_status_cells: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cs_fall |=> tx_r[14] == $past(pll_lock) && tx_r[8] == $past(fifo_empty))
    else $error("status cells out of order");
  a_count_thresh: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cs_fall |=> tx_r[10] == ($past(fifo_fill_count) > $past(fifo_threshold_level)))
    else $error("count threshold wrong");
  a_power_poll: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && cs_act && !cs_fall && !started_r && !sck_fall ##1 ce && cs_act
    |-> spi_miso == $past(power_ready)) else $error("miso does not follow ready");
  a_sample_rise: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && sck_rise |=> bit_cnt_r == $past(bit_cnt_r) + 3'h1)
    else $error("bit not counted on rising edge");
  a_buf_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    buf_cnt_r <= BUF_FULL_CNT) else $error("write buffer overfilled");

endmodule : srp_port

// ===== dv/srp_host.sv
// srp_host: serial bus master model that drives the port's link pins.
// assumes mclk is the core clock; one link half period is four mclk cycles.
`timescale 1ns/10ps
module srp_host (
  input wire logic mclk,
  input wire logic miso,
  output logic sclk,
  output logic mosi,
  output logic cs_n
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b1;
    cs_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  // released data line shows the inverse of its last bit, never a held value
  task automatic sel(input logic lo);
    cs_n <= ~lo;
    mosi <= ~mosi;
    wt(lo ? 4 : 6);
  endtask : sel
  // mode 0, msb first; sclk idles low between frames
  task automatic xfer(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      mosi <= tx[7-i];
      wt(4);
      sclk <= 1'b1;
      wt(4);
      rx = {rx[6:0], miso};
      sclk <= 1'b0;
    end
    wt(1);
  endtask : xfer
endmodule : srp_host

// ===== dv/testbench.sv
// testbench: self-checking bench for srp_port with a host model.
// assumes a combinational register file model and a stallable write sink.
`timescale 1ns/10ps
module testbench;
  import srp_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst, ce, power_ready;
  logic spi_sclk, spi_mosi, spi_cs_n, spi_miso, spi_miso_oe_n, rd_req, access_busy;
  logic miso_line;
  logic wr_valid, wr_ready, wr_overrun, wr_overrun_clr;
  logic [11:0] reg_raddr, wr_addr, fl;
  logic [7:0] reg_rdata, wr_data, rx;
  logic [15:0] fr, fc, th, sw;
  logic [19:0] wq[$];
  int num_errors = 0, n_tests = 0;
  always #12.5 mclk = ~mclk;
  assign reg_rdata = reg_raddr[7:0] ^ 8'h5a;
  always @(posedge mclk) if (wr_valid === 1'b1 && wr_ready) wq.push_back({wr_addr, wr_data});
  // a released line shows the inverse, so a host that reads it unselected sees garbage
  assign miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;
  srp_host i_srp_host (.mclk(mclk), .miso(miso_line), .sclk(spi_sclk), .mosi(spi_mosi),
    .cs_n(spi_cs_n));
  srp_port i_srp_port (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .power_ready(power_ready), .rd_req(rd_req),
    .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .wr_overrun(wr_overrun),
    .wr_overrun_clr(wr_overrun_clr), .access_busy(access_busy),
    .pll_lock(fl[0]), .fifo_over(fl[1]), .fifo_under(fl[2]),
    .fifo_full(fl[3]), .fifo_empty(fl[4]), .power_good_flag(fl[5]),
    .pwr_irq_pending(fl[6]), .radio_event_pending(fl[7]), .xtal_running(fl[8]),
    .wakeup_irq_pending(fl[9]), .low_power_oscillator_irq(fl[10]),
    .auxiliary_adc_irq(fl[11]), .fifo_free_space(fr), .fifo_fill_count(fc),
    .fifo_threshold_level(th));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] exps();
    return {power_ready, fl[0], fl[1], fl[2], fr > th, fc > th, fl[3], fl[4],
      fl[5], fl[6], fl[7], fl[8], fl[9], fl[10], fl[11], 1'b0};
  endfunction : exps
  task automatic t_sread();
    fl <= 12'ha53;
    fr <= 16'h0010;
    fc <= 16'h0011;
    th <= 16'h0010;
    i_srp_host.sel(1'b1);
    i_srp_host.xfer(8, 8'h05, rx);
    sw = exps();
    chk(rx, sw[15:8]);
    for (int k = 0; k < 2; k++) begin
      i_srp_host.xfer(8, 8'h00, rx);
      chk(rx, 8'((8'h05 + k) ^ 8'h5a));
    end
    i_srp_host.sel(1'b0);
  endtask : t_sread
  task automatic t_lread();
    fl <= 12'h5ac;
    fr <= 16'h0021;
    fc <= 16'h0020;
    th <= 16'h0020;
    i_srp_host.sel(1'b1);
    i_srp_host.xfer(8, 8'h71, rx);
    sw = exps();
    chk(rx, sw[15:8]);
    i_srp_host.xfer(8, 8'h23, rx);
    chk(rx, sw[7:0]);
    for (int k = 0; k < 3; k++) begin
      i_srp_host.xfer(8, 8'h00, rx);
      chk(rx, 8'((8'h23 + k) ^ 8'h5a));
    end
    i_srp_host.sel(1'b0);
  endtask : t_lread
  // sink stalls, so the third data byte finds the two-entry buffer full
  task automatic t_write();
    wq.delete();
    i_srp_host.sel(1'b1);
    for (int k = 0; k < 4; k++) i_srp_host.xfer(8, k ? 8'(8'hc0 + k) : 8'h90, rx);
    i_srp_host.sel(1'b0);
    chk(wr_overrun, 1'b1);
    chk(20'(wq.size()), 20'h0);
    wr_ready <= 1'b1;
    i_srp_host.wt(4);
    chk(20'(wq.size()), 20'h2);
    chk(wq[0], {12'h010, 8'hc1});
    chk(wq[1], {12'h011, 8'hc2});
    chk(wr_overrun, 1'b1);
    wr_overrun_clr <= 1'b1;
    i_srp_host.wt(1);
    wr_overrun_clr <= 1'b0;
    i_srp_host.wt(1);
    chk(wr_overrun, 1'b0);
  endtask : t_write
  task automatic t_abort();
    wq.delete();
    i_srp_host.sel(1'b1);
    i_srp_host.xfer(4, 8'hf0, rx);
    i_srp_host.sel(1'b0);
    i_srp_host.sel(1'b1);
    i_srp_host.xfer(8, 8'hf0, rx);
    i_srp_host.xfer(8, 8'hf2, rx);
    i_srp_host.xfer(8, 8'h3c, rx);
    i_srp_host.sel(1'b0);
    chk(20'(wq.size()), 20'h1);
    chk(wq[0], {12'h0f2, 8'h3c});
  endtask : t_abort
  // a low enable hides a whole frame: nothing is seen, driven or written
  task automatic t_freeze();
    wq.delete();
    ce <= 1'b0;
    i_srp_host.sel(1'b1);
    i_srp_host.xfer(8, 8'h85, rx);
    chk({spi_miso_oe_n, access_busy}, 2'b10);
    i_srp_host.xfer(8, 8'h3c, rx);
    i_srp_host.sel(1'b0);
    ce <= 1'b1;
    i_srp_host.wt(4);
    chk(20'(wq.size()), 20'h0);
  endtask : t_freeze
  task automatic t_wake();
    power_ready <= 1'b0;
    i_srp_host.sel(1'b1);
    i_srp_host.wt(4);
    chk({spi_miso, spi_miso_oe_n, access_busy}, 3'b001);
    power_ready <= 1'b1;
    i_srp_host.wt(8);
    chk(spi_miso, 1'b1);
    i_srp_host.sel(1'b0);
    chk({spi_miso_oe_n, access_busy}, 2'b10);
  endtask : t_wake
  task automatic results();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    #200000;
    num_errors++;
    results();
  end
  initial begin
    sys_rst <= 1'b1;
    ce <= 1'b1;
    power_ready <= 1'b1;
    wr_ready <= 1'b0;
    wr_overrun_clr <= 1'b0;
    fl <= 12'h000;
    fr <= 16'h0000;
    fc <= 16'h0000;
    th <= 16'h0000;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    i_srp_host.wt(2);
    t_sread();
    t_lread();
    t_write();
    t_abort();
    t_freeze();
    t_wake();
    results();
  end
endmodule : testbench
